// File: drmd_ctl_map.svh
`ifndef DRMD_CTL_MAP_SVH
`define DRMD_CTL_MAP_SVH

// Sample width of one audio channel word.
`define DRMD_SW 24

// Register indices; the byte address on the bus is four times the index.
`define DRMD_IDX_INSEL 6'h0F
`define DRMD_IDX_MIXZF 6'h10
`define DRMD_IDX_PER_DAC_DEEMPH_EN 6'h11
`define DRMD_IDX_SRC 6'h18
`define DRMD_IDX_STATUS 6'h19
`define DRMD_IDX_ISTAT 6'h1A
`define DRMD_IDX_IMASK 6'h1B

// Reset values.
`define DRMD_RST_INSEL 9'h0E4
`define DRMD_RST_MIXZF 8'h09
`define DRMD_RST_PER_DAC_DEEMPH_EN 5'h00
`define DRMD_RST_SRC 2'h3
`define DRMD_RST_IRQ 5'h00

// Field positions.
`define DRMD_INSEL_MODE 8
`define DRMD_MIX_LO 0
`define DRMD_ZFS_LO 4
`define DRMD_IZD_BIT 7
`define DRMD_GLOB_BIT 4
`define DRMD_SRC_SPDIF 2'h0

// Consecutive zero samples before a DAC counts as infinite zero.
`define DRMD_ZERO_RUN 1024

`endif

// File: drmd_pkg.sv
`include "drmd_ctl_map.svh"

package drmd_pkg;

    // One stereo sample: left and right words travel together.
    typedef struct packed {
        logic signed [`DRMD_SW-1:0] l;
        logic signed [`DRMD_SW-1:0] r;
    } drmd_pair_t;

    // Two-bit output mixing codes for one output side.
    typedef enum logic [1:0] {
        DRMD_MIX_MUTE = 2'h0,
        DRMD_MIX_LEFT = 2'h1,
        DRMD_MIX_RIGHT = 2'h2,
        DRMD_MIX_AVG = 2'h3
    } drmd_mix_t;

endpackage

// File: drmd_mix.sv
`timescale 1ns/10ps
`include "drmd_ctl_map.svh"

module drmd_mix
    import drmd_pkg::*;
(
    input wire drmd_pair_t in_i,
    input wire logic [3:0] sel_i,
    output drmd_pair_t out_o
);

    logic signed [`DRMD_SW:0] sum;
    logic signed [`DRMD_SW-1:0] avg;

    // Average keeps one extra bit so the sum cannot wrap before halving.
    assign sum = {in_i.l[`DRMD_SW-1], in_i.l} + {in_i.r[`DRMD_SW-1], in_i.r};
    assign avg = sum[`DRMD_SW:1];

    function automatic logic [`DRMD_SW-1:0] pick(input logic [1:0] code);
        case (drmd_mix_t'(code))
            DRMD_MIX_MUTE: pick = '0;
            DRMD_MIX_LEFT: pick = in_i.l;
            DRMD_MIX_RIGHT: pick = in_i.r;
            default: pick = avg;
        endcase
    endfunction

    // Low two bits steer the left output, high two bits the right.
    always_comb begin
        out_o.l = pick(sel_i[1:0]);
        out_o.r = pick(sel_i[3:2]);
    end

endmodule

// File: drmd_top.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "drmd_ctl_map.svh"

// Contract
// - Zero flag source code 000 gives all-DACs zero, 001 to 100 DAC1-4.
// - Automute bit 7 enables infinite-zero automute when set; resets clear.
// - Per-DAC de-emphasis bits, bit 0 for DAC1 upward; reset 0000.
// - With global bit 4 clear, de-emphasis follows the per-DAC field only.
// - Mode bit 8 acts only with S/PDIF source; set: frame clock sets rate.
// - Each two-bit input selector routes serial input one to four.
// - Source code 00 feeds DAC1 from S/PDIF data and enables the mode bit.
module drmd_top
    import drmd_pkg::*;
#(
    parameter int unsigned ZERO_RUN = `DRMD_ZERO_RUN
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire drmd_pair_t [3:0] serial_data_in_i,
    input wire drmd_pair_t spdif_rx_i,
    input wire logic in_valid_i,
    output drmd_pair_t [3:0] dac_o,
    output logic dac_valid_o,
    output logic [3:0] dac_deemph_o,
    output logic [3:0] dac_automute_o,
    output logic [3:0] dac_off_o,
    output logic dac_rate_from_primary_o,
    output logic zero_flag_out_o,
    output logic irq_o
);

    localparam int ZW = $clog2(ZERO_RUN + 1);

    // Everything the block remembers sits in this one record.
    typedef struct packed {
        logic [8:0] insel;
        logic [7:0] mixzf;
        logic [4:0] per_dac_deemph_en;
        logic [1:0] src;
        logic [4:0] istat;
        logic [4:0] imask;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        drmd_pair_t [3:0] dac;
        logic dvalid;
        logic [3:0] deemph;
        logic [3:0] amute;
        logic [3:0] off;
        logic rate_pri;
        logic zero_flag_out;
        logic [3:0][ZW-1:0] zcnt;
    } drmd_state_t;

    drmd_state_t s;
    drmd_state_t next_s;
    drmd_pair_t [3:0] src_pair;
    drmd_pair_t [3:0] mixed;
    logic [3:0] zero_s;
    logic spdif_src;
    logic wr_go;
    logic [5:0] idx;
    logic [15:0] wdat;
    logic [4:0] clr;
    logic [4:0] set;
    logic [31:0] rval;

    // Byte lanes 0 and 1 carry every writable field.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
        merge = {sel[1] ? dat[15:8] : old[15:8],
                 sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    // A DAC holds infinite zero once its run counter has saturated.
    function automatic logic is_zero(input logic [ZW-1:0] cnt);
        is_zero = (cnt == ZW'(ZERO_RUN));
    endfunction

    assign spdif_src = (s.src == `DRMD_SRC_SPDIF);
    assign idx = wb_adr_i[7:2];
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;

    // Source routing ahead of the mixers.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            src_pair[i] = serial_data_in_i[s.insel[2*i +: 2]];
        end
        if (spdif_src) begin
            src_pair[0] = spdif_rx_i;
        end
    end

    // One mixer per DAC, all steered by the shared selector.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mix
            drmd_mix u_mix (
                .in_i(src_pair[g]),
                .sel_i(s.mixzf[`DRMD_MIX_LO +: 4]),
                .out_o(mixed[g])
            );
            assign zero_s[g] = is_zero(s.zcnt[g]);
        end
    endgenerate

    // Read mux; unmapped words read as zero and still get an ack.
    always_comb begin
        case (idx)
            `DRMD_IDX_INSEL: rval = {23'h000000, s.insel};
            `DRMD_IDX_MIXZF: rval = {24'h000000, s.mixzf};
            `DRMD_IDX_PER_DAC_DEEMPH_EN: rval = {27'h0000000, s.per_dac_deemph_en};
            `DRMD_IDX_SRC: rval = {30'h00000000, s.src};
            `DRMD_IDX_STATUS: rval = {18'h00000, s.rate_pri, s.off, s.amute,
                                      zero_s, s.zero_flag_out};
            `DRMD_IDX_ISTAT: rval = {27'h0000000, s.istat};
            `DRMD_IDX_IMASK: rval = {27'h0000000, s.imask};
            default: rval = 32'h00000000;
        endcase
    end

    // Next-state logic for the bus, the fields and the sample path.
    always_comb begin
        next_s = s;
        wdat = 16'h0000;
        clr = 5'h00;
        set = 5'h00;
        next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
        next_s.rdat = next_s.ack ? rval : 32'h00000000;
        // Writes land on the edge where the master sees ack high.
        if (wr_go) begin
            case (idx)
                `DRMD_IDX_INSEL: begin
                    wdat = merge({7'h00, s.insel}, wb_dat_i, wb_sel_i);
                    next_s.insel = wdat[8:0];
                end
                `DRMD_IDX_MIXZF: begin
                    wdat = merge({8'h00, s.mixzf}, wb_dat_i, wb_sel_i);
                    next_s.mixzf = wdat[7:0];
                end
                `DRMD_IDX_PER_DAC_DEEMPH_EN: begin
                    wdat = merge({11'h000, s.per_dac_deemph_en}, wb_dat_i, wb_sel_i);
                    next_s.per_dac_deemph_en = wdat[4:0];
                end
                `DRMD_IDX_SRC: begin
                    wdat = merge({14'h0000, s.src}, wb_dat_i, wb_sel_i);
                    next_s.src = wdat[1:0];
                end
                `DRMD_IDX_ISTAT: begin
                    wdat = merge(16'h0000, wb_dat_i, wb_sel_i);
                    clr = wdat[4:0];
                end
                `DRMD_IDX_IMASK: begin
                    wdat = merge({11'h000, s.imask}, wb_dat_i, wb_sel_i);
                    next_s.imask = wdat[4:0];
                end
                default: begin
                    wdat = 16'h0000;
                end
            endcase
        end
        // Sample path: mixed words are taken on each input strobe.
        next_s.dvalid = in_valid_i;
        if (in_valid_i) begin
            for (int i = 0; i < 4; i++) begin
                next_s.dac[i] = mixed[i];
                if (src_pair[i] == '0) begin
                    if (!is_zero(s.zcnt[i])) begin
                        next_s.zcnt[i] = s.zcnt[i] + ZW'(1);
                    end
                end else begin
                    next_s.zcnt[i] = '0;
                end
            end
            // Powered-down DACs play silence instead of stale words.
            for (int i = 1; i < 4; i++) begin
                if (spdif_src && !s.insel[`DRMD_INSEL_MODE]) begin
                    next_s.dac[i] = '0;
                end
            end
        end
        // Mode bit is meaningless unless S/PDIF feeds DAC1.
        next_s.rate_pri = spdif_src & s.insel[`DRMD_INSEL_MODE];
        next_s.off = {{3{spdif_src & ~s.insel[`DRMD_INSEL_MODE]}}, 1'b0};
        // De-emphasis: the global bit forces all four on.
        next_s.deemph = s.per_dac_deemph_en[`DRMD_GLOB_BIT] ? 4'hF : s.per_dac_deemph_en[3:0];
        next_s.amute = {4{s.mixzf[`DRMD_IZD_BIT]}} & zero_s;
        // Reserved selector codes hold the flag low.
        case (s.mixzf[`DRMD_ZFS_LO +: 3])
            3'h0: next_s.zero_flag_out = &zero_s;
            3'h1: next_s.zero_flag_out = zero_s[0];
            3'h2: next_s.zero_flag_out = zero_s[1];
            3'h3: next_s.zero_flag_out = zero_s[2];
            3'h4: next_s.zero_flag_out = zero_s[3];
            default: next_s.zero_flag_out = 1'b0;
        endcase
        // Events: a DAC entering infinite zero, and the flag rising.
        // Looked at inside this process so no signal loops back into it.
        for (int i = 0; i < 4; i++) begin
            set[i] = is_zero(next_s.zcnt[i]) & ~zero_s[i];
        end
        set[4] = next_s.zero_flag_out & ~s.zero_flag_out;
        // Set beats a clear arriving in the same cycle.
        next_s.istat = (s.istat & ~clr) | set;
        next_s.irq = |(next_s.istat & next_s.imask);
    end

    // Single state register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.insel <= `DRMD_RST_INSEL;
            s.mixzf <= `DRMD_RST_MIXZF;
            s.per_dac_deemph_en <= `DRMD_RST_PER_DAC_DEEMPH_EN;
            s.src <= `DRMD_RST_SRC;
            s.istat <= `DRMD_RST_IRQ;
            s.imask <= `DRMD_RST_IRQ;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign irq_o = s.irq;
    assign dac_o = s.dac;
    assign dac_valid_o = s.dvalid;
    assign dac_deemph_o = s.deemph;
    assign dac_automute_o = s.amute;
    assign dac_off_o = s.off;
    assign dac_rate_from_primary_o = s.rate_pri;
    assign zero_flag_out_o = s.zero_flag_out;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_zero_flag_out_dac1: assert property (
        (s.mixzf[6:4] == 3'h1 && zero_s[0]) |=> zero_flag_out_o)
        else $error("zero flag did not follow DAC1 zero");

    a_zero_flag_out_all: assert property (
        (s.mixzf[6:4] == 3'h0 && !zero_s[3]) |=> !zero_flag_out_o)
        else $error("all-DAC zero flag raised with DAC4 active");

    a_automute_off: assert property (
        !s.mixzf[7] |=> dac_automute_o == 4'h0)
        else $error("automute active while disabled");

    a_reset_vals: assert property (
        $past(rst_i) |-> (s.per_dac_deemph_en == 5'h00 && s.mixzf == 8'h09))
        else $error("control fields wrong after reset");

    a_deemph_per: assert property (
        !s.per_dac_deemph_en[4] |=> dac_deemph_o == $past(s.per_dac_deemph_en[3:0]))
        else $error("de-emphasis not per-DAC with global clear");

    a_mode_gate: assert property (
        (s.src != 2'h0) |=> !dac_rate_from_primary_o ##0 dac_off_o == 4'h0)
        else $error("S/PDIF mode acted without S/PDIF source");

    a_mix_mute: assert property (
        (in_valid_i && s.mixzf[3:0] == 4'h0) |=> dac_o[1] == '0)
        else $error("mute mix code passed data");

    a_route_sel: assert property (
        (in_valid_i && s.mixzf[3:0] == 4'h9 && s.insel[3:2] == 2'h2
         && s.src != 2'h0)
        |=> dac_o[1] == $past(serial_data_in_i[2]))
        else $error("DAC2 not fed from third input");

    a_spdif_route: assert property (
        (in_valid_i && s.mixzf[3:0] == 4'h9 && s.src == 2'h0)
        |=> dac_o[0] == $past(spdif_rx_i))
        else $error("DAC1 not fed from S/PDIF");

    a_zero_flag_out_dac4: assert property (
        s.mixzf[6:4] == 3'h4 |=> zero_flag_out_o == $past(zero_s[3]))
        else $error("zero flag did not follow DAC4 zero");

    a_zero_flag_out_resv: assert property (
        s.mixzf[6:4] > 3'h4 |=> !zero_flag_out_o)
        else $error("reserved zero flag code raised the flag");

    a_dac_off: assert property (
        (s.src == 2'h0 && !s.insel[8]) |=> dac_off_o == 4'hE)
        else $error("DAC2 to DAC4 not off with S/PDIF source");

    a_rate_pri: assert property (
        (s.src == 2'h0 && s.insel[8]) |=> dac_rate_from_primary_o)
        else $error("frame clock rate not selected in mode one");

    a_deemph_all: assert property (
        s.per_dac_deemph_en[4] |=> dac_deemph_o == 4'hF)
        else $error("global de-emphasis did not cover all DACs");

    a_wb_ack: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle after request");

endmodule

// File: tb_top.sv
`timescale 1ns/10ps

module tb_top;
    import drmd_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic iv = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    drmd_pair_t [3:0] din;
    drmd_pair_t [3:0] dac_o;
    drmd_pair_t spd;
    logic dac_valid_o;
    logic [3:0] deemph;
    logic [3:0] amute;
    logic [3:0] off;
    logic rate;
    logic zero_flag_out;
    logic irq;
    logic [3:0] de;
    logic [4:0] dv [4] = '{5'h05, 5'h0A, 5'h10, 5'h15};
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    // Free-running 50 MHz clock.
    always #10 clk_i = ~clk_i;

    // A short zero run keeps the infinite-zero tests brief.
    drmd_top #(.ZERO_RUN(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .serial_data_in_i(din), .spdif_rx_i(spd), .in_valid_i(iv),
        .dac_o(dac_o), .dac_valid_o(dac_valid_o), .dac_deemph_o(deemph),
        .dac_automute_o(amute), .dac_off_o(off),
        .dac_rate_from_primary_o(rate), .zero_flag_out_o(zero_flag_out),
        .irq_o(irq)
    );

    task automatic results;
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkp(input string n, input drmd_pair_t e,
                        input drmd_pair_t g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // Read data is taken only at the edge where ack is seen high.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One sample strobe; the outputs land one edge later.
    task automatic smp;
        iv <= 1'b1;
        @(posedge clk_i);
        iv <= 1'b0;
        @(posedge clk_i);
        chk("dac_valid", 32'h1, 32'(dac_valid_o));
    endtask

    // Average is an arithmetic shift of the widened sum, truncated.
    function automatic logic [23:0] pick(input logic [1:0] c,
                                         input drmd_pair_t s);
        logic signed [24:0] sum;
        sum = 25'(s.l) + 25'(s.r);
        case (c)
            2'h0: return 24'h0;
            2'h1: return s.l;
            2'h2: return s.r;
            default: return sum[24:1];
        endcase
    endfunction

    function automatic drmd_pair_t mixp(input logic [3:0] c,
                                        input drmd_pair_t s);
        mixp.l = pick(c[1:0], s);
        mixp.r = pick(c[3:2], s);
    endfunction

    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            results();
        end
    end

    // Main sequence of register and sample tests.
    initial begin
        for (int k = 0; k < 4; k++) begin
            din[k] <= '{l: 24'(256 * (k + 1)), r: 24'(4096 * (k + 1))};
        end
        spd <= '{l: 24'h000777, r: 24'h000333};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(8'h3C, 32'h0E4);
        rdc(8'h40, 32'h09);
        rdc(8'h44, 32'h00);
        rdc(8'h60, 32'h03);
        wr(8'h70, 32'hFF);
        rdc(8'h70, 32'h00);
        for (int s = 0; s < 4; s++) begin
            wr(8'h3C, 32'h0E0 | 32'(s * 5));
            smp();
            chkp("dac1", din[s], dac_o[0]);
            chkp("dac2", din[s], dac_o[1]);
            chkp("dac4", din[3], dac_o[3]);
        end
        wr(8'h3C, 32'h0E4);
        for (int c = 0; c < 16; c++) begin
            wr(8'h40, 32'(c));
            smp();
            chkp("mix", mixp(4'(c), din[0]), dac_o[0]);
        end
        wr(8'h40, 32'h09);
        for (int i = 0; i < 4; i++) begin
            wr(8'h44, 32'(dv[i]));
            wt(2);
            de = dv[i][4] ? 4'hF : dv[i][3:0];
            chk("deemph", 32'(de), 32'(deemph));
            rdc(8'h44, 32'(dv[i]));
        end
        wr(8'h44, 32'h00);
        wr(8'h60, 32'h00);
        smp();
        chkp("spdif", spd, dac_o[0]);
        chkp("dac2_off", '0, dac_o[1]);
        chk("dac_off", 32'hE, 32'(off));
        chk("rate", 32'h0, 32'(rate));
        wr(8'h3C, 32'h1E4);
        wt(2);
        chk("rate", 32'h1, 32'(rate));
        wr(8'h60, 32'h03);
        wt(2);
        chk("rate", 32'h0, 32'(rate));
        wr(8'h3C, 32'h0E4);
        din[0] <= '0;
        repeat (5) smp();
        wt(2);
        rdc(8'h68, 32'h01);
        // Mask is clear after reset, so the pending event stays quiet.
        chk("irq", 32'h0, 32'(irq));
        wr(8'h6C, 32'h1F);
        wt(2);
        chk("irq", 32'h1, 32'(irq));
        wr(8'h68, 32'h1F);
        wt(2);
        chk("irq", 32'h0, 32'(irq));
        wr(8'h6C, 32'h00);
        rdc(8'h68, 32'h00);
        rdc(8'h64, 32'h02);
        for (int z = 0; z < 8; z++) begin
            wr(8'h40, 32'(z * 16 + 9));
            wt(2);
            chk("zero_flag", 32'(z == 1), 32'(zero_flag_out));
        end
        wr(8'h40, 32'h89);
        wt(2);
        chk("automute", 32'h1, 32'(amute));
        wr(8'h40, 32'h09);
        wt(2);
        chk("automute", 32'h0, 32'(amute));
        results();
    end
endmodule
